// File: rtl/scer_event_regs.sv
// combiner header and event flag register bank
`timescale 1ns/1ps
`default_nettype none
module scer_event_regs
  import scer_pkg::*;
#(
  parameter logic [15:0] MODEL_ID = 16'h00a5, // arbitrary value
  parameter logic [15:0] CURRENT_SF = 16'h0000,
  parameter logic [15:0] AMPHOUR_SF = 16'h0000,
  parameter logic [15:0] VOLTAGE_SF = UNSUPPORTED_INT16,
  parameter logic [15:0] MAX_CURRENT = 16'h0280,
  parameter logic [15:0] INPUT_COUNT = 16'h0020
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [NUM_STRINGS*16-1:0] string_current,
  input wire logic [15:0] on_threshold,
  input wire logic [15:0] blink_threshold,
  input wire logic polarity_reversed_pin,
  input wire logic subsystem_comm_fault_pin,
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  output logic [NUM_STRINGS*FLAGS_PER_STRING-1:0] string_indicator_flags,
  output logic [31:0] combiner_event_word,
  output logic [31:0] combiner_vendor_event_word
);

  scer_state_t st_reg;
  scer_state_t st_next;
  logic [FLAGS_PER_STRING-1:0] flags_or;
  logic both_lit;
  logic [15:0] first_cur;
  logic [15:0] last_cur;
  logic [15:0] first_mag;
  logic [15:0] last_mag;

  always_comb begin
    logic [15:0] cur;
    logic [16:0] mag;
    logic [FLAGS_PER_STRING-1:0] acc;
    cur = 16'h0000;
    mag = 17'h0_0000;
    acc = '0;
    st_next = st_reg;
    st_next.polarity_sync = {st_reg.polarity_sync[0], polarity_reversed_pin};
    st_next.comm_sync = {st_reg.comm_sync[0], subsystem_comm_fault_pin};
    for (int i = 0; i < NUM_STRINGS; i++) begin
      cur = string_current[i*16 +: 16];
      mag = cur[15] ? (17'h0_0000 - {1'b1, cur}) : {1'b0, cur};
      // flags are set side by side; positive and negative flow exclude each other, over-range may join either
      st_next.string_flags[i*FLAGS_PER_STRING + BIT_POSITIVE_FLOW_LIT] =
        !cur[15] && (mag > {1'b0, on_threshold});
      st_next.string_flags[i*FLAGS_PER_STRING + BIT_NEGATIVE_FLOW_LIT] =
        cur[15] && (mag > {1'b0, on_threshold});
      st_next.string_flags[i*FLAGS_PER_STRING + BIT_OVERRANGE_BLINKING] =
        mag > {1'b0, blink_threshold};
      acc = acc | st_reg.string_flags[i*FLAGS_PER_STRING +: FLAGS_PER_STRING];
    end
    st_next.vendor_word = {29'h0000_0000, acc};
    st_next.event_word = EVENT_RESET;
    st_next.event_word[BIT_CURRENT_OUT_OF_RANGE] = acc[BIT_OVERRANGE_BLINKING];
    st_next.event_word[BIT_POLARITY_REVERSED] = st_reg.polarity_sync[1];
    st_next.event_word[BIT_SUBSYSTEM_COMM_FAULT] = st_reg.comm_sync[1];
    st_next.rd_valid = rd_en;
    st_next.rd_error = 1'b0;
    st_next.rd_data = READ_RESET;
    if (rd_en) begin
      // addresses compared as absolute base-one register numbers
      unique case (rd_addr)
        REG_MODEL_ID: st_next.rd_data = MODEL_ID;
        REG_BLOCK_LEN: st_next.rd_data = BLOCK_LEN;
        REG_CURRENT_SF: st_next.rd_data = CURRENT_SF;
        REG_AMPHOUR_SF: st_next.rd_data = AMPHOUR_SF;
        REG_VOLTAGE_SF: st_next.rd_data = VOLTAGE_SF;
        REG_MAX_CURRENT: st_next.rd_data = MAX_CURRENT;
        REG_INPUT_COUNT: st_next.rd_data = INPUT_COUNT;
        REG_EVENT_HI: st_next.rd_data = st_reg.event_word[31:16];
        REG_EVENT_LO: st_next.rd_data = st_reg.event_word[15:0];
        REG_VENDOR_HI: st_next.rd_data = st_reg.vendor_word[31:16];
        REG_VENDOR_LO: st_next.rd_data = st_reg.vendor_word[15:0];
        default: st_next.rd_error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign rd_valid = st_reg.rd_valid;
  assign rd_error = st_reg.rd_error;
  // string words carry only the three indicator flags
  assign string_indicator_flags = st_reg.string_flags;
  assign combiner_event_word = st_reg.event_word;
  assign combiner_vendor_event_word = st_reg.vendor_word;

  // helper for checks: OR of registered string flags
  always_comb begin
    flags_or = '0;
    both_lit = 1'b0;
    for (int i = 0; i < NUM_STRINGS; i++) begin
      flags_or = flags_or | st_reg.string_flags[i*FLAGS_PER_STRING +: FLAGS_PER_STRING];
      both_lit = both_lit | (st_reg.string_flags[i*FLAGS_PER_STRING + BIT_POSITIVE_FLOW_LIT]
        & st_reg.string_flags[i*FLAGS_PER_STRING + BIT_NEGATIVE_FLOW_LIT]);
    end
  end

  // 16-bit magnitude of first and last string, most negative code reads 0x8000
  always_comb begin
    first_cur = string_current[15:0];
    last_cur = string_current[NUM_STRINGS*16-1 -: 16];
    first_mag = first_cur[15] ? 16'(~first_cur + 16'h0001) : first_cur;
    last_mag = last_cur[15] ? 16'(~last_cur + 16'h0001) : last_cur;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  a_vendor_or_summary: assert property (
    ##1 combiner_vendor_event_word[2:0] == $past(flags_or))
    else $error("summary vendor word is not the OR of string words");

  a_vendor_unused_zero: assert property (
    combiner_vendor_event_word[31:3] == 29'h0000_0000)
    else $error("unused vendor bits not zero");

  a_event_only_known: assert property (
    (combiner_event_word & ~32'h0000_a008) == 32'h0000_0000)
    else $error("undefined combiner event bit set");

  a_polarity_flag: assert property (
    ##3 combiner_event_word[BIT_POLARITY_REVERSED] == $past(polarity_reversed_pin, 3))
    else $error("polarity flag does not follow pin after sync");

  a_comm_fault_flag: assert property (
    ##3 combiner_event_word[BIT_SUBSYSTEM_COMM_FAULT] == $past(subsystem_comm_fault_pin, 3))
    else $error("comm fault flag does not follow pin after sync");

  a_overrange_event: assert property (
    ##1 combiner_event_word[BIT_CURRENT_OUT_OF_RANGE] == $past(flags_or[BIT_OVERRANGE_BLINKING]))
    else $error("out of range bit does not track blink flags");

  a_green_red_exclusive: assert property (
    !(string_indicator_flags[BIT_POSITIVE_FLOW_LIT] && string_indicator_flags[BIT_NEGATIVE_FLOW_LIT]))
    else $error("string 1 lit green and red together");

  a_green_string_one: assert property (
    (!string_current[15] && (string_current[15:0] > on_threshold))
    |=> string_indicator_flags[BIT_POSITIVE_FLOW_LIT])
    else $error("positive flow flag missing on string 1");

  a_read_model_id: assert property (
    (rd_en && rd_addr == REG_MODEL_ID) |=> (rd_valid && !rd_error && rd_data == MODEL_ID))
    else $error("model identifier read wrong");

  a_read_block_len: assert property (
    (rd_en && rd_addr == REG_BLOCK_LEN) |=> (rd_valid && rd_data == 16'h0110))
    else $error("block length read wrong");

  a_read_voltage_sf: assert property (
    (rd_en && rd_addr == REG_VOLTAGE_SF) |=> (rd_data == VOLTAGE_SF))
    else $error("voltage scale read wrong");

  a_read_event_lo: assert property (
    (rd_en && rd_addr == REG_EVENT_LO) |=> (rd_data == $past(combiner_event_word[15:0])))
    else $error("event low word read wrong");

  a_unmapped_error: assert property (
    (rd_en && (rd_addr < REG_MODEL_ID || rd_addr > REG_VENDOR_LO)) |=> (rd_valid && rd_error))
    else $error("unmapped read not flagged");

  a_read_valid_pulse: assert property (
    ##1 rd_valid == $past(rd_en))
    else $error("read answer not one cycle after request");

  a_idle_read_quiet: assert property (
    !rd_valid |-> (rd_data == READ_RESET && !rd_error))
    else $error("read port active without a request");

  a_error_data_zero: assert property (
    rd_error |-> (rd_valid && rd_data == READ_RESET))
    else $error("error answer carries data");

  a_mapped_no_error: assert property (
    (rd_en && rd_addr >= REG_MODEL_ID && rd_addr <= REG_VENDOR_LO) |=> (rd_valid && !rd_error))
    else $error("mapped read flagged as error");

  a_read_current_sf: assert property (
    (rd_en && rd_addr == REG_CURRENT_SF) |=> (!rd_error && rd_data == CURRENT_SF))
    else $error("current scale read wrong");

  a_read_amphour_sf: assert property (
    (rd_en && rd_addr == REG_AMPHOUR_SF) |=> (!rd_error && rd_data == AMPHOUR_SF))
    else $error("amp-hour scale read wrong");

  a_read_max_current: assert property (
    (rd_en && rd_addr == REG_MAX_CURRENT) |=> (!rd_error && rd_data == MAX_CURRENT))
    else $error("maximum current read wrong");

  a_read_input_count: assert property (
    (rd_en && rd_addr == REG_INPUT_COUNT) |=> (!rd_error && rd_data == INPUT_COUNT))
    else $error("input count read wrong");

  a_read_event_hi: assert property (
    (rd_en && rd_addr == REG_EVENT_HI) |=> (rd_data == $past(combiner_event_word[31:16])))
    else $error("event high word read wrong");

  a_read_vendor_hi: assert property (
    (rd_en && rd_addr == REG_VENDOR_HI)
    |=> (rd_data == $past(combiner_vendor_event_word[31:16])))
    else $error("vendor high word read wrong");

  a_read_vendor_lo: assert property (
    (rd_en && rd_addr == REG_VENDOR_LO)
    |=> (rd_data == $past(combiner_vendor_event_word[15:0])))
    else $error("vendor low word read wrong");

  a_green_off_one: assert property (
    (first_cur[15] || first_mag <= on_threshold)
    |=> !string_indicator_flags[BIT_POSITIVE_FLOW_LIT])
    else $error("positive flow flag set without cause on string 1");

  a_red_string_one: assert property (
    (first_cur[15] && first_mag > on_threshold)
    |=> string_indicator_flags[BIT_NEGATIVE_FLOW_LIT])
    else $error("negative flow flag missing on string 1");

  a_red_off_one: assert property (
    (!first_cur[15] || first_mag <= on_threshold)
    |=> !string_indicator_flags[BIT_NEGATIVE_FLOW_LIT])
    else $error("negative flow flag set without cause on string 1");

  a_blink_string_one: assert property (
    (first_mag > blink_threshold)
    |=> string_indicator_flags[BIT_OVERRANGE_BLINKING])
    else $error("over-range flag missing on string 1");

  a_blink_off_one: assert property (
    (first_mag <= blink_threshold)
    |=> !string_indicator_flags[BIT_OVERRANGE_BLINKING])
    else $error("over-range flag set without cause on string 1");

  a_green_last_string: assert property (
    (!last_cur[15] && last_mag > on_threshold)
    |=> string_indicator_flags[(NUM_STRINGS-1)*FLAGS_PER_STRING + BIT_POSITIVE_FLOW_LIT])
    else $error("positive flow flag missing on last string");

  a_green_off_last: assert property (
    (last_cur[15] || last_mag <= on_threshold)
    |=> !string_indicator_flags[(NUM_STRINGS-1)*FLAGS_PER_STRING + BIT_POSITIVE_FLOW_LIT])
    else $error("positive flow flag set without cause on last string");

  a_red_last_string: assert property (
    (last_cur[15] && last_mag > on_threshold)
    |=> string_indicator_flags[(NUM_STRINGS-1)*FLAGS_PER_STRING + BIT_NEGATIVE_FLOW_LIT])
    else $error("negative flow flag missing on last string");

  a_blink_last_string: assert property (
    (last_mag > blink_threshold)
    |=> string_indicator_flags[(NUM_STRINGS-1)*FLAGS_PER_STRING + BIT_OVERRANGE_BLINKING])
    else $error("over-range flag missing on last string");

  a_blink_off_last: assert property (
    (last_mag <= blink_threshold)
    |=> !string_indicator_flags[(NUM_STRINGS-1)*FLAGS_PER_STRING + BIT_OVERRANGE_BLINKING])
    else $error("over-range flag set without cause on last string");

  a_no_double_lit: assert property (
    !both_lit)
    else $error("a string lit green and red together");

  a_overrange_needs_blink: assert property (
    combiner_event_word[BIT_CURRENT_OUT_OF_RANGE]
    == combiner_vendor_event_word[BIT_OVERRANGE_BLINKING])
    else $error("out of range bit disagrees with summary blink flag");

  c_read_vendor_lo: cover property (rd_en && rd_addr == REG_VENDOR_LO ##1 rd_data != 16'h0000);
  c_negative_lit: cover property (string_indicator_flags[BIT_NEGATIVE_FLOW_LIT]);
  c_overrange_seen: cover property (combiner_event_word[BIT_CURRENT_OUT_OF_RANGE]);
  c_polarity_seen: cover property (combiner_event_word[BIT_POLARITY_REVERSED]);
  c_unmapped_read: cover property (rd_error);

endmodule // scer_event_regs
`default_nettype wire

// File: rtl/scer_pkg.sv
// constants, register numbers and state type of the combiner event register bank
package scer_pkg;

  localparam int NUM_STRINGS = 32;
  localparam int FLAGS_PER_STRING = 3;

  // register numbers, absolute, base one
  localparam logic [15:0] REG_MODEL_ID = 16'h9c86;
  localparam logic [15:0] REG_BLOCK_LEN = 16'h9c87;
  localparam logic [15:0] REG_CURRENT_SF = 16'h9c88;
  localparam logic [15:0] REG_AMPHOUR_SF = 16'h9c89;
  localparam logic [15:0] REG_VOLTAGE_SF = 16'h9c8a;
  localparam logic [15:0] REG_MAX_CURRENT = 16'h9c8b;
  localparam logic [15:0] REG_INPUT_COUNT = 16'h9c8c;
  localparam logic [15:0] REG_EVENT_HI = 16'h9c8d;
  localparam logic [15:0] REG_EVENT_LO = 16'h9c8e;
  localparam logic [15:0] REG_VENDOR_HI = 16'h9c8f;
  localparam logic [15:0] REG_VENDOR_LO = 16'h9c90;

  localparam logic [15:0] BLOCK_LEN_BASE = 16'h0010;
  localparam logic [15:0] BLOCK_PER_INPUT = 16'h0008;
  localparam logic [15:0] BLOCK_LEN = 16'(BLOCK_LEN_BASE + BLOCK_PER_INPUT * NUM_STRINGS);

  localparam logic [15:0] UNSUPPORTED_INT16 = 16'h8000;

  // combiner event word bit positions
  localparam int BIT_CURRENT_OUT_OF_RANGE = 3;
  localparam int BIT_POLARITY_REVERSED = 13;
  localparam int BIT_SUBSYSTEM_COMM_FAULT = 15;

  // indicator flag positions, shared by summary and per-string words
  localparam int BIT_POSITIVE_FLOW_LIT = 0;
  localparam int BIT_NEGATIVE_FLOW_LIT = 1;
  localparam int BIT_OVERRANGE_BLINKING = 2;

  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [15:0] READ_RESET = 16'h0000;

  typedef struct packed {
    logic [1:0] polarity_sync;
    logic [1:0] comm_sync;
    logic [NUM_STRINGS*FLAGS_PER_STRING-1:0] string_flags;
    logic [31:0] event_word;
    logic [31:0] vendor_word;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_error;
  } scer_state_t;

endpackage

// File: bench/scer_master_model.sv
// polling master model on the read port
`timescale 1ns/1ps
`default_nettype none
module scer_master_model (
  input wire logic mclk,
  output logic rd_en,
  output logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_error
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 16'h0000;
  end
  // address inverted once released, so a stale value never matches
  task automatic read(input logic [15:0] a, output logic [15:0] d, output logic v,
                      output logic e);
    @(posedge mclk);
    #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge mclk);
    #1;
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
    v = rd_valid;
    e = rd_error;
  endtask
endmodule // scer_master_model
`default_nettype wire

// File: bench/scer_event_regs_bench.sv
// self-checking bench for the combiner event register bank
`timescale 1ns/1ps
`default_nettype none
module scer_event_regs_bench;
  import scer_pkg::*;
  localparam logic [15:0] MID = 16'h005a; // arbitrary value
  localparam logic [15:0] CSF = 16'hfffe;
  localparam logic [15:0] ASF = 16'h0001;
  localparam logic [15:0] MAXC = 16'h0280;
  localparam logic [15:0] NIN = 16'h0020;
  logic mclk, rstn, pol, comm, rd_en, rd_valid, rd_error, v, e;
  logic [NUM_STRINGS*16-1:0] cur;
  logic [15:0] on_thr, blk_thr, rd_addr, rd_data, d;
  logic [95:0] sflags, xf;
  logic [31:0] ev, vev, seed, r, xe, xv;
  logic [15:0] tab[7];
  logic [15:0] c_cur[3] = '{16'h8000, 16'h0000, 16'h0100};
  logic [15:0] c_on[3] = '{16'h7fff, 16'h0000, 16'h0100};
  logic [15:0] c_blk[3] = '{16'h7fff, 16'h0000, 16'h00ff};
  int error_cnt, n_checks;

  scer_event_regs #(.MODEL_ID(MID), .CURRENT_SF(CSF), .AMPHOUR_SF(ASF),
    .VOLTAGE_SF(UNSUPPORTED_INT16), .MAX_CURRENT(MAXC), .INPUT_COUNT(NIN)) i_dut (
    .mclk(mclk), .rstn(rstn), .string_current(cur), .on_threshold(on_thr),
    .blink_threshold(blk_thr), .polarity_reversed_pin(pol), .subsystem_comm_fault_pin(comm),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .string_indicator_flags(sflags), .combiner_event_word(ev),
    .combiner_vendor_event_word(vev));
  scer_master_model i_master (.mclk(mclk), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_error));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // magnitude in 17 bits so the most negative current compares correctly
  function automatic logic [95:0] exp_flags(input logic [511:0] c, input logic [15:0] on,
                                            input logic [15:0] bl);
    logic [16:0] m;
    logic [15:0] s;
    exp_flags = '0;
    for (int i = 0; i < NUM_STRINGS; i++) begin
      s = c[16*i +: 16];
      m = s[15] ? 17'(~{1'b1, s} + 17'd1) : {1'b0, s};
      exp_flags[3*i] = !s[15] && m > {1'b0, on};
      exp_flags[3*i+1] = s[15] && m > {1'b0, on};
      exp_flags[3*i+2] = m > {1'b0, bl};
    end
  endfunction
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input logic err);
    i_master.read(a, d, v, e);
    chk(96'({d, v, e}), 96'({exp, 1'b1, err}));
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    seed = 32'h0000b5dd;
    rstn = 1'b0;
    cur = '0;
    on_thr = 16'h0000;
    blk_thr = 16'h0000;
    pol = 1'b0;
    comm = 1'b0;
    tab = '{MID, 16'(16 + NUM_STRINGS * 8), CSF, ASF, UNSUPPORTED_INT16, MAXC, NIN};
    repeat (16) @(posedge mclk);
    #1;
    rstn = 1'b1;
    for (int k = 0; k < 7; k++) begin
      rdchk(REG_MODEL_ID + 16'(k), tab[k], 1'b0);
    end
    rdchk(16'h9c85, 16'h0000, 1'b1);
    rdchk(16'h9c91, 16'h0000, 1'b1);
    for (int it = 0; it < 40; it++) begin
      @(posedge mclk);
      #1;
      r = xs();
      for (int i = 0; i < NUM_STRINGS; i++) begin
        cur[16*i +: 16] = it < 3 ? c_cur[it] : 16'($signed(xs()) >>> 19);
      end
      on_thr = it < 3 ? c_on[it] : {4'h0, r[11:0]};
      blk_thr = it < 3 ? c_blk[it] : {4'h0, r[27:16]};
      pol = r[12];
      comm = r[13];
      repeat (5) @(posedge mclk);
      #1;
      xf = exp_flags(cur, on_thr, blk_thr);
      xv = '0;
      for (int i = 0; i < NUM_STRINGS; i++) begin
        xv[2:0] = xv[2:0] | xf[3*i +: 3];
      end
      xe = {16'h0000, comm, 1'b0, pol, 9'h000, xv[2], 3'h0};
      chk(sflags, xf);
      chk(96'(vev), 96'(xv));
      chk(96'(ev), 96'(xe));
      rdchk(REG_EVENT_HI, xe[31:16], 1'b0);
      rdchk(REG_EVENT_LO, xe[15:0], 1'b0);
      rdchk(REG_VENDOR_HI, xv[31:16], 1'b0);
      rdchk(REG_VENDOR_LO, xv[15:0], 1'b0);
    end
    test_done();
  end
endmodule // scer_event_regs_bench
`default_nettype wire
